// *** dv/gac_clk_src.sv ***
`timescale 1ns/100ps
`default_nettype none
module gac_clk_src
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [7:0] n_edges,
   input  wire logic       go,
   output var  logic       ext_clk_pin,
   output var  logic       busy
);
   logic [7:0] left;
   logic [2:0] ph;
   ////////////////////////////////////////////////////////////////////////
   // burst of rising edges, 8 mclk per period; stands low between bursts
   // so no stray edge reaches the counter while software writes it
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         left <= 8'h00;
         ph   <= 3'h0;
      end
      else if (go)
      begin
         left <= n_edges;
         ph   <= 3'h0;
      end
      else if (left != 8'h00)
      begin
         ph <= ph + 3'h1;
         if (ph == 3'h7)
            left <= left - 8'h01;
      end
   end
   assign busy        = (left != 8'h00);
   assign ext_clk_pin = busy & ph[2];
endmodule : gac_clk_src
`default_nettype wire

// *** dv/gac_counter_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module gac_counter_tb_top;
   logic       mclk = 1'b0;
   logic       rst_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       ext_clk_pin, busy, irq, wake_req;
   logic       gate_pin = 1'b0;
   logic       cmp1 = 1'b0;
   logic       cmp2 = 1'b0;
   logic       sleep_mode = 1'b0;
   logic [7:0] n_edges = 8'h00;
   logic       go = 1'b0;
   int         err_count = 0;
   int         n_compared = 0;
   logic [15:0] cnt;
   logic [7:0]  rv;

   always #50 mclk = ~mclk;

   gac_counter #(.COUNT_W(16)) DUT
   (
      .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_clk_pin(ext_clk_pin),
      .gate_pin(gate_pin), .comparator_one_output(cmp1),
      .comparator_two_output(cmp2), .sleep_mode(sleep_mode),
      .irq(irq), .wake_req(wake_req)
   );
   gac_clk_src src
   (
      .mclk(mclk), .rst_n(rst_n), .n_edges(n_edges), .go(go),
      .ext_clk_pin(ext_clk_pin), .busy(busy)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // counter is stopped before each read pair, so no wrap between them
   task automatic rd16(output logic [15:0] v);
      rd(3'h2, v[7:0]);
      rd(3'h3, v[15:8]);
   endtask : rd16

   task automatic set_count(input logic [15:0] v);
      wr(3'h3, v[15:8]);
      wr(3'h2, v[7:0]);
   endtask : set_count

   // bounded wait, then room for the synchronizer and prescaler stages
   task automatic edges(input logic [7:0] n);
      int i;
      @(posedge mclk);
      n_edges <= n;
      go      <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      // busy only shows at the edge after go is taken
      @(posedge mclk);
      for (i = 0; i < 4000 && busy; i++)
         @(posedge mclk);
      chk("burst finished", {15'h0, busy}, 16'h0000);
      repeat (8) @(posedge mclk);
   endtask : edges

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int a = 0; a < 8; a++)
      begin
         rd(3'(a), rv);
         chk("reset reg", {8'h00, rv}, 16'h0000);
      end
      chk("reset irq", {15'h0, irq}, 16'h0000);
   endtask : t_reset

   task automatic t_prescale;
      for (int b = 0; b < 2; b++)
         for (int p = 0; p < 4; p++)
         begin
            wr(3'h0, {2'h0, 2'(p), 1'b0, 1'(b), 2'h3});
            set_count(16'h0000);
            edges(8'h08);
            rd16(cnt);
            chk("prescaled count", cnt, 16'h0008 >> p);
         end
      wr(3'h0, 8'h33);
      set_count(16'h0000);
      edges(8'h04);
      wr(3'h2, 8'h10);
      edges(8'h06);
      rd16(cnt);
      chk("prescaler clear", cnt, 16'h0010);
   endtask : t_prescale

   task automatic t_gate;
      logic lvl;
      wr(3'h0, 8'h03);
      for (int s = 0; s < 4; s++)
         for (int p = 0; p < 2; p++)
            for (int act = 0; act < 2; act++)
            begin
               if (s == 1)
                  continue;
               lvl = act ? 1'(p) : ~1'(p);
               gate_pin <= (s == 0) ? lvl : ~lvl;
               cmp1     <= (s == 2) ? lvl : ~lvl;
               cmp2     <= (s == 3) ? lvl : ~lvl;
               wr(3'h1, {1'b1, 1'(p), 1'(p), 3'h0, 2'(s)});
               set_count(16'h0000);
               repeat (4) @(posedge mclk);
               edges(8'h03);
               rd16(cnt);
               chk("gated count", cnt, act ? 16'h3 : 16'h0);
            end
      gate_pin <= 1'b1;
      wr(3'h1, 8'h00);
      set_count(16'h0000);
      edges(8'h03);
      rd16(cnt);
      chk("free count", cnt, 16'h0003);
      // internal source: on for exactly two edges between the two writes
      wr(3'h0, 8'h01);
      wr(3'h0, 8'h00);
      rd16(cnt);
      chk("internal free count", cnt, 16'h0005);
   endtask : t_gate

   task automatic t_aux;
      wr(3'h0, 8'h01);
      wr(3'h1, 8'hC1);
      wr(3'h6, 8'h00);
      set_count(16'h0000);
      wr(3'h7, 8'h01);
      repeat (600) @(posedge mclk);
      wr(3'h7, 8'h00);
      wr(3'h0, 8'h00);
      rd16(cnt);
      chk("aux gated count", cnt, 16'h0002);
      rd(3'h4, rv);
      chk("aux status", {8'h00, rv}, 16'h0002);
      chk("masked irq", {15'h0, irq}, 16'h0000);
      wr(3'h5, 8'h02);
      repeat (2) @(posedge mclk);
      chk("irq on", {14'h0, irq, wake_req}, 16'h0002);
      wr(3'h4, 8'h02);
      repeat (2) @(posedge mclk);
      chk("irq cleared", {15'h0, irq}, 16'h0000);
   endtask : t_aux

   task automatic t_sleep;
      wr(3'h1, 8'h00);
      wr(3'h5, 8'h01);
      wr(3'h0, 8'h07);
      set_count(16'hFFFE);
      sleep_mode <= 1'b1;
      edges(8'h02);
      rd16(cnt);
      chk("wrapped count", cnt, 16'h0000);
      rd(3'h4, rv);
      chk("ovf status", {8'h00, rv}, 16'h0001);
      chk("wake", {14'h0, irq, wake_req}, 16'h0003);
      wr(3'h4, 8'h01);
      wr(3'h0, 8'h03);
      edges(8'h03);
      rd16(cnt);
      chk("synced sleep", cnt, 16'h0000);
      sleep_mode <= 1'b0;
   endtask : t_sleep

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_prescale();
      t_gate();
      t_aux();
      t_sleep();
      close_out();
   end

   // all scenarios need well under 8000 cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_count++;
      close_out();
   end
endmodule : gac_counter_tb_top
`default_nettype wire

// *** logic/gac_aux_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module gac_aux_timer
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       enable,
   input  wire logic       load,
   input  wire logic [7:0] load_value,
   output var  logic [7:0] value,
   output var  logic       wrap
);
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         value <= gac_pkg::RST_REG;
      else if (load)
         value <= load_value;
      else if (enable)
         value <= value + 8'h01;
   end

   // one-cycle pulse on the rollover; a load in that cycle suppresses it
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         wrap <= 1'b0;
      else
         wrap <= enable && !load && (value == gac_pkg::AUX_MAX);
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_aux_wrap_pulse : assert property (
      enable && !load && value == gac_pkg::AUX_MAX
      |=> wrap && value == 8'h00 ##1 !wrap)
      else $error("aux wrap pulse missing or too long");
endmodule : gac_aux_timer
`default_nettype wire

// *** logic/gac_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module gac_counter
#(
   parameter int COUNT_W = 16
)
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   input  wire logic       ext_clk_pin,
   input  wire logic       gate_pin,
   input  wire logic       comparator_one_output,
   input  wire logic       comparator_two_output,
   input  wire logic       sleep_mode,
   output var  logic       irq,
   output var  logic       wake_req
);
   generate
      if (COUNT_W != 2 * gac_pkg::DATA_W)
      begin : g_bad_width
         $error("count width must be two data bytes");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // functions
   function automatic logic [2:0] psc_limit(input logic [1:0] sel);
      logic [2:0] lim;
      lim = 3'h0;
      case (sel)
         2'h0:    lim = 3'h0;
         2'h1:    lim = 3'h1;
         2'h2:    lim = 3'h3;
         default: lim = 3'h7;
      endcase
      return lim;
   endfunction : psc_limit

   function automatic logic wr_hit(input logic       wr,
                                   input logic [2:0] a,
                                   input logic [2:0] ofs);
      return wr && (a == ofs);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]         ctrl;
   logic [7:0]         gcon;
   logic [7:0]         status;
   logic [7:0]         mask;
   logic [7:0]         auxctl;
   logic [COUNT_W-1:0] count;
   logic [2:0]         psc;
   logic [7:0]         aux_value;
   logic               aux_timer_wrap;
   logic               cnt_wr_lo;
   logic               cnt_wr_hi;
   logic               cnt_wr;
   logic               aux_wr;

   assign cnt_wr_lo = wr_hit(reg_wr, reg_addr, gac_pkg::OFS_CNT_LO);
   assign cnt_wr_hi = wr_hit(reg_wr, reg_addr, gac_pkg::OFS_CNT_HI);
   assign cnt_wr    = cnt_wr_lo || cnt_wr_hi;
   assign aux_wr    = wr_hit(reg_wr, reg_addr, gac_pkg::OFS_AUX);

   logic               sync_bypass_bit;
   logic               ext_sel;
   logic               cnt_on;
   logic [1:0]         prescale_select;
   logic               gate_enable_bit;
   logic               gate_polarity_bit;
   logic               comp_sync_bit;
   gac_pkg::gac_gss_t  gate_source_select;

   assign cnt_on            = ctrl[gac_pkg::CTL_ON];
   assign ext_sel           = ctrl[gac_pkg::CTL_EXT];
   assign sync_bypass_bit   = ctrl[gac_pkg::CTL_BYPASS];
   assign prescale_select   = ctrl[gac_pkg::CTL_PSC_HI:gac_pkg::CTL_PSC_LO];
   assign gate_enable_bit   = gcon[gac_pkg::GCN_GE];
   assign gate_polarity_bit = gcon[gac_pkg::GCN_POL];
   assign comp_sync_bit     = gcon[gac_pkg::GCN_CSYNC];
   assign gate_source_select =
      gac_pkg::gac_gss_t'(gcon[gac_pkg::GCN_GSS_HI:gac_pkg::GCN_GSS_LO]);

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ctrl   <= gac_pkg::RST_REG;
         gcon   <= gac_pkg::RST_REG;
         mask   <= gac_pkg::RST_REG;
         auxctl <= gac_pkg::RST_REG;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            gac_pkg::OFS_CTRL:   ctrl   <= reg_wdata;
            gac_pkg::OFS_GATE:   gcon   <= reg_wdata;
            gac_pkg::OFS_MASK:   mask   <= reg_wdata & gac_pkg::ST_USED;
            gac_pkg::OFS_AUXCTL: auxctl <= reg_wdata;
            default:             ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage feeds only the second
   logic [1:0] pin_s1;
   logic [1:0] pin_s2;
   logic       ext_s3;
   logic       ext_s4;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pin_s1 <= 2'h0;
         pin_s2 <= 2'h0;
      end
      else
      begin
         pin_s1 <= {gate_pin, ext_clk_pin};
         pin_s2 <= pin_s1;
      end
   end

   // extra stage models alignment to the internal phase clocks
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ext_s3 <= 1'b0;
         ext_s4 <= 1'b0;
      end
      else
      begin
         ext_s3 <= pin_s2[0];
         ext_s4 <= ext_s3;
      end
   end

   logic ext_rise_fast;
   logic ext_rise_slow;
   logic src_edge;
   assign ext_rise_fast = pin_s2[0] && !ext_s3;
   assign ext_rise_slow = ext_s3 && !ext_s4;
   // the two paths differ by one cycle, so a mode change can merge or
   // split an edge; accepted instead of a guard that stalls the count
   assign src_edge = !ext_sel        ? 1'b1          :
                     sync_bypass_bit ? ext_rise_fast :
                                       ext_rise_slow;

   ////////////////////////////////////////////////////////////////////////
   // comparator inputs come from on-chip logic; optional resync
   logic [1:0] cmp_s1;
   logic [1:0] cmp_s2;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cmp_s1 <= 2'h0;
         cmp_s2 <= 2'h0;
      end
      else
      begin
         cmp_s1 <= {comparator_two_output, comparator_one_output};
         cmp_s2 <= cmp_s1;
      end
   end

   logic c1_gate;
   logic c2_gate;
   logic gate_sig;
   logic gate_open;
   assign c1_gate = comp_sync_bit ? cmp_s2[0] : comparator_one_output;
   assign c2_gate = comp_sync_bit ? cmp_s2[1] : comparator_two_output;

   always_comb
   begin
      case (gate_source_select)
         gac_pkg::GAC_GSS_PIN:  gate_sig = pin_s2[1];
         gac_pkg::GAC_GSS_AUX:  gate_sig = aux_timer_wrap;
         gac_pkg::GAC_GSS_CMP1: gate_sig = c1_gate;
         gac_pkg::GAC_GSS_CMP2: gate_sig = c2_gate;
         default:               gate_sig = 1'b0;
      endcase
   end

   // free run unless gated; gated runs only at the chosen level
   assign gate_open = !gate_enable_bit ||
                      (gate_sig == gate_polarity_bit);

   ////////////////////////////////////////////////////////////////////////
   // counting
   logic run_ok;
   logic tick;
   logic inc;
   logic overflow;
   // only an unsynchronized external source keeps running in sleep
   assign run_ok   = !sleep_mode || (ext_sel && sync_bypass_bit);
   assign tick     = cnt_on && run_ok && gate_open && src_edge;
   assign inc      = tick && (psc == psc_limit(prescale_select));
   assign overflow = inc && !cnt_wr && (count == gac_pkg::COUNT_MAX);

   // prescaler has no address; any count byte write clears it
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         psc <= gac_pkg::RST_PSC;
      else if (cnt_wr)
         psc <= gac_pkg::RST_PSC;
      else if (inc)
         psc <= gac_pkg::RST_PSC;
      else if (tick)
         psc <= psc + 3'h1;
   end

   // a byte write wins over a coinciding increment
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         count <= gac_pkg::RST_COUNT;
      else if (cnt_wr_lo)
         count[7:0] <= reg_wdata;
      else if (cnt_wr_hi)
         count[15:8] <= reg_wdata;
      else if (inc)
         count <= count + 16'h0001;
   end

   gac_aux_timer u_aux
   (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .enable     (auxctl[gac_pkg::AUX_EN]),
      .load       (aux_wr),
      .load_value (reg_wdata),
      .value      (aux_value),
      .wrap       (aux_timer_wrap)
   );

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: set wins over write-one-to-clear
   logic [7:0] st_set;
   logic [7:0] st_clr;
   assign st_set = {6'h00, aux_timer_wrap, overflow};
   assign st_clr = wr_hit(reg_wr, reg_addr, gac_pkg::OFS_STATUS) ?
                   reg_wdata : 8'h00;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         status <= gac_pkg::RST_REG;
      else
         status <= ((status & ~st_clr) | st_set) & gac_pkg::ST_USED;
   end
   logic next_irq;
   assign next_irq = |(((status & ~st_clr) | st_set) & mask);

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         irq      <= 1'b0;
         wake_req <= 1'b0;
      end
      else
      begin
         irq      <= next_irq;
         wake_req <= next_irq && sleep_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register reads: every byte is a settled mclk-domain value
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         reg_rdata <= gac_pkg::RST_REG;
      else if (reg_rd)
      begin
         case (reg_addr)
            gac_pkg::OFS_CTRL:   reg_rdata <= ctrl;
            gac_pkg::OFS_GATE:   reg_rdata <= gcon;
            gac_pkg::OFS_CNT_LO: reg_rdata <= count[7:0];
            gac_pkg::OFS_CNT_HI: reg_rdata <= count[15:8];
            gac_pkg::OFS_STATUS: reg_rdata <= status;
            gac_pkg::OFS_MASK:   reg_rdata <= mask;
            gac_pkg::OFS_AUX:    reg_rdata <= aux_value;
            default:             reg_rdata <= auxctl;
         endcase
      end
      else
         reg_rdata <= gac_pkg::RST_REG;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_roll;
      inc && count == gac_pkg::COUNT_MAX && !cnt_wr;
   endsequence
   sequence s_flag_then_irq;
      status[gac_pkg::ST_OVF] ##1 irq;
   endsequence

   a_bypass_path : assert property (
      ext_sel && sync_bypass_bit |-> src_edge == ext_rise_fast)
      else $error("bypass mode not using the short path");
   a_sync_path : assert property (
      ext_sel && !sync_bypass_bit |-> src_edge == $past(ext_rise_fast))
      else $error("synchronized path not one cycle later");
   a_sleep_hold : assert property (
      sleep_mode && !(ext_sel && sync_bypass_bit) && !cnt_wr
      |=> count == $past(count))
      else $error("counter moved in sleep without bypass");
   a_single_step : assert property (
      !cnt_wr |=> count == $past(count) ||
                  count == $past(count) + 16'h0001)
      else $error("counter stepped by more than one");
   a_read_low : assert property (
      reg_rd && reg_addr == gac_pkg::OFS_CNT_LO
      |=> reg_rdata == $past(count[7:0]) ##1 reg_rdata == 8'h00
          || $past(reg_rd))
      else $error("low count byte read wrong");
   a_free_run : assert property (
      !gate_enable_bit && cnt_on && !ext_sel && !sleep_mode
      && prescale_select == 2'h0 && !cnt_wr
      |=> count == $past(count) + 16'h0001)
      else $error("free running counter did not step");
   a_gate_count : assert property (
      gate_enable_bit && gate_sig == gate_polarity_bit && cnt_on
      && !ext_sel && !sleep_mode && prescale_select == 2'h0 && !cnt_wr
      |=> count == $past(count) + 16'h0001)
      else $error("active gate did not let the counter step");
   a_gate_hold : assert property (
      gate_enable_bit && gate_sig != gate_polarity_bit && !cnt_wr
      |=> $stable(count))
      else $error("inactive gate let the counter move");
   a_gate_select : assert property (
      gate_source_select == gac_pkg::GAC_GSS_AUX
      |-> gate_sig == aux_timer_wrap)
      else $error("gate source select not honoured");
   a_comp_sync : assert property (
      comp_sync_bit && gate_source_select == gac_pkg::GAC_GSS_CMP1
      |-> gate_sig == $past(comparator_one_output, 2))
      else $error("synchronized comparator path wrong");
   a_psc_clear : assert property (
      cnt_wr |=> psc == gac_pkg::RST_PSC)
      else $error("prescaler not cleared by count write");
   a_ovf_flag : assert property (
      s_roll |=> count == gac_pkg::RST_COUNT && status[gac_pkg::ST_OVF])
      else $error("overflow did not wrap and flag");
   a_ovf_irq : assert property (
      s_roll ##1 mask[gac_pkg::ST_OVF] |-> s_flag_then_irq)
      else $error("unmasked overflow did not raise the interrupt");
endmodule : gac_counter
`default_nettype wire

// *** logic/gac_pkg.sv ***
// How it works
// - bypass bit skips the extra clock-alignment stage
// - unsynchronized external counting continues in sleep, wakes
// - mode switches may drop or add one increment
// - count byte reads always return settled values
// - counter runs freely or under gate control
// - gate-enable bit selects gated mode
// - polarity bit picks gate active level
// - active gate lets counter step on clock edges
// - inactive gate holds the present count
// - two-bit select picks pin, aux wrap, comparators
// - aux wrap pulses on eight-bit rollover to zero
// - comparator gate inputs optionally synchronized
// - prescaler hidden, cleared by count byte writes
`default_nettype none
package gac_pkg;
   localparam int          DATA_W = 8;
   localparam int          ADDR_W = 3;
   localparam int          PSC_W  = 3;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [2:0]  OFS_CTRL   = 3'h0;
   localparam logic [2:0]  OFS_GATE   = 3'h1;
   localparam logic [2:0]  OFS_CNT_LO = 3'h2;
   localparam logic [2:0]  OFS_CNT_HI = 3'h3;
   localparam logic [2:0]  OFS_STATUS = 3'h4;
   localparam logic [2:0]  OFS_MASK   = 3'h5;
   localparam logic [2:0]  OFS_AUX    = 3'h6;
   localparam logic [2:0]  OFS_AUXCTL = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // counter_control_reg fields
   localparam int          CTL_ON     = 0;
   localparam int          CTL_EXT    = 1;
   localparam int          CTL_BYPASS = 2;
   localparam int          CTL_PSC_LO = 4;
   localparam int          CTL_PSC_HI = 5;
   // gate_control_reg fields
   localparam int          GCN_GSS_LO = 0;
   localparam int          GCN_GSS_HI = 1;
   localparam int          GCN_CSYNC  = 5;
   localparam int          GCN_POL    = 6;
   localparam int          GCN_GE     = 7;
   // status / mask fields
   localparam int          ST_OVF     = 0;
   localparam int          ST_AUX     = 1;
   localparam logic [7:0]  ST_USED    = 8'h03;
   // aux control field
   localparam int          AUX_EN     = 0;

   ////////////////////////////////////////////////////////////////////////
   // reset values and count maxima
   localparam logic [7:0]  RST_REG    = 8'h00;
   localparam logic [15:0] RST_COUNT  = 16'h0000;
   localparam logic [2:0]  RST_PSC    = 3'h0;
   localparam logic [7:0]  AUX_MAX    = 8'hFF;
   localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

   typedef enum logic [1:0]
   {
      GAC_GSS_PIN  = 2'h0,
      GAC_GSS_AUX  = 2'h1,
      GAC_GSS_CMP1 = 2'h2,
      GAC_GSS_CMP2 = 2'h3
   } gac_gss_t;
endpackage : gac_pkg
`default_nettype wire
